// ---- hw/rcri_reset_init.sv ----
`timescale 1ns/1ns

module rcri_reset_init (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rstn,
   // Reset causes from the reset circuitry, asynchronous levels
   input wire rcri_pkg::rcri_cause_t cause_async,
   // Core events on this clock
   input wire logic sleep_enter,
   input wire logic irq_wake,
   input wire rcri_pkg::rcri_wake_set_t wake_set,
   // Core register access
   input wire rcri_pkg::rcri_wr_t wr,
   input wire rcri_pkg::rcri_idx_t rd_idx,
   output logic [7:0] rd_data,
   // Register contents
   output logic [rcri_pkg::REG_COUNT-1:0][7:0] reg_file,
   // Cause observation
   output logic asleep,
   output rcri_pkg::rcri_class_t last_class,
   output logic vector_taken
);

   // ----------------------------------------------------------------
   // Cause synchronisation and class decode
   // ----------------------------------------------------------------
   rcri_pkg::rcri_cause_t cause;
   rcri_pkg::rcri_class_t cls;
   logic wdt_prev;
   logic wdt_event;
   logic wdt_reset;
   logic wake_by_wdt;
   logic wake_by_irq;
   logic [7:0] pc_low_byte;
   logic [7:0] status;
   logic [7:0] irq_control_reg;
   logic [7:0] periph_flag_reg_a;
   logic [7:0] periph_flag_reg_b;
   logic [7:0] power_control_reg;

   rcri_sync2 #(
      .W($bits(rcri_pkg::rcri_cause_t))
   ) u_cause_sync (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .d_async(cause_async),
      .q_sync(cause)
   );

   // Watchdog timeout edge, taken from the synchronised level
   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
         wdt_prev <= 1'b0;
      else
         wdt_prev <= cause.wdt;
   end

   // Watchdog edge resets an awake core and wakes a sleeping one
   assign wdt_event = cause.wdt & ~wdt_prev;
   assign wdt_reset = wdt_event & ~asleep;
   assign wake_by_wdt = wdt_event & asleep;
   assign wake_by_irq = irq_wake & asleep & ~wake_by_wdt;

   // Power class first, then pin or watchdog, then wake-up
   always_comb
   begin
      cls.power = cause.por | cause.bor;
      cls.pin_wdt = ~cls.power & (cause.pin | wdt_reset);
      cls.wake = ~cls.power & ~cls.pin_wdt
         & (wake_by_wdt | wake_by_irq);
   end

   // Sleep tracking: any class ends sleep
   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
         asleep <= 1'b0;
      else if (cls.power | cls.pin_wdt | cls.wake)
         asleep <= 1'b0;
      else if (sleep_enter)
         asleep <= 1'b1;
   end

   // Last class applied, held until the next one
   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
         last_class <= '{power: 1'b1, pin_wdt: 1'b0, wake: 1'b0};
      else if (cls.power | cls.pin_wdt | cls.wake)
         last_class <= cls;
   end

   // ----------------------------------------------------------------
   // Program counter low byte
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
         pc_low_byte <= rcri_pkg::PC_RESET_VAL;
      else if (cls.power | cls.pin_wdt)
         pc_low_byte <= rcri_pkg::PC_RESET_VAL;
      else if (cls.wake)
      begin
         if (wake_by_irq & irq_control_reg[rcri_pkg::IRQ_GIE_BIT])
            pc_low_byte <= rcri_pkg::PC_VECTOR;
         else
            pc_low_byte <= pc_low_byte + rcri_pkg::PC_STEP;
      end
      else if (wr.en && wr.idx == rcri_pkg::IDX_PC_LOW_BYTE)
         pc_low_byte <= wr.data;
   end

   // Pulse when the wake-up jumped to the interrupt vector
   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
         vector_taken <= 1'b0;
      else
         vector_taken <= cls.wake & wake_by_irq
            & irq_control_reg[rcri_pkg::IRQ_GIE_BIT];
   end

   // ----------------------------------------------------------------
   // Core status register
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
         status <= rcri_pkg::STATUS_POWER_VAL;
      else if (cls.power)
         status <= rcri_pkg::STATUS_POWER_VAL
            | (status & rcri_pkg::STATUS_LOW_MASK);
      else if (cls.pin_wdt)
      begin
         status <= status & ~rcri_pkg::STATUS_BANK_MASK;
         if (cause.pin & asleep)
         begin
            status[rcri_pkg::STATUS_TO_BIT] <= 1'b1;
            status[rcri_pkg::STATUS_PD_BIT] <= 1'b0;
         end
         else if (~cause.pin)
         begin
            status[rcri_pkg::STATUS_TO_BIT] <= 1'b0;
            status[rcri_pkg::STATUS_PD_BIT] <= 1'b1;
         end
      end
      else if (cls.wake)
      begin
         status[rcri_pkg::STATUS_TO_BIT] <= ~wake_by_wdt;
         status[rcri_pkg::STATUS_PD_BIT] <= 1'b0;
      end
      else if (wr.en && wr.idx == rcri_pkg::IDX_STATUS)
         status <= wr.data;
   end

   // ----------------------------------------------------------------
   // Power control register
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
         power_control_reg <= rcri_pkg::BYTE_ZERO;
      else if (cause.por)
         power_control_reg[rcri_pkg::POWER_CONTROL_REG_POR_BIT] <= 1'b0;
      else if (cause.bor)
         power_control_reg[rcri_pkg::POWER_CONTROL_REG_BOR_BIT] <= 1'b0;
      else if (~cls.pin_wdt & ~cls.wake & wr.en
            && wr.idx == rcri_pkg::IDX_POWER_CONTROL)
         power_control_reg <= wr.data & rcri_pkg::POWER_CONTROL_REG_IMPL;
   end

   // ----------------------------------------------------------------
   // Interrupt control and peripheral flags
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
         irq_control_reg <= rcri_pkg::BYTE_ZERO;
      else if (cls.power | cls.pin_wdt)
         irq_control_reg <= irq_control_reg
            & rcri_pkg::IRQ_RESET_KEEP;
      else if (cls.wake)
         irq_control_reg <= irq_control_reg | wake_set.irq_ctl;
      else if (wr.en && wr.idx == rcri_pkg::IDX_IRQ_CONTROL)
         irq_control_reg <= wr.data;
   end

   // Reserved top bit is forced clear on every load
   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
         periph_flag_reg_a <= rcri_pkg::BYTE_ZERO;
      else if (cls.power | cls.pin_wdt)
         periph_flag_reg_a <= rcri_pkg::BYTE_ZERO;
      else if (cls.wake)
         periph_flag_reg_a <= (periph_flag_reg_a | wake_set.flag_a)
            & rcri_pkg::FLAG_A_IMPL;
      else if (wr.en && wr.idx == rcri_pkg::IDX_PERIPH_FLAG_A)
         periph_flag_reg_a <= wr.data & rcri_pkg::FLAG_A_IMPL;
   end

   // Second flag register, one implemented bit
   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
         periph_flag_reg_b <= rcri_pkg::BYTE_ZERO;
      else if (cls.power | cls.pin_wdt)
         periph_flag_reg_b <= rcri_pkg::BYTE_ZERO;
      else if (cls.wake)
         periph_flag_reg_b <= (periph_flag_reg_b | wake_set.flag_b)
            & rcri_pkg::FLAG_B_IMPL;
      else if (wr.en && wr.idx == rcri_pkg::IDX_PERIPH_FLAG_B)
         periph_flag_reg_b <= wr.data & rcri_pkg::FLAG_B_IMPL;
   end

   // ----------------------------------------------------------------
   // Register file: table-driven cells and the special registers
   // ----------------------------------------------------------------
   // Each table entry fixes one cell's per-class behaviour; the six special indices ignore theirs
   for (genvar i = 0; i < rcri_pkg::REG_COUNT; i++)
   begin : g_reg
      if (i == int'(rcri_pkg::IDX_PC_LOW_BYTE))
      begin : g_pc
         assign reg_file[i] = pc_low_byte;
      end
      else if (i == int'(rcri_pkg::IDX_STATUS))
      begin : g_status
         assign reg_file[i] = status;
      end
      else if (i == int'(rcri_pkg::IDX_IRQ_CONTROL))
      begin : g_irq
         assign reg_file[i] = irq_control_reg;
      end
      else if (i == int'(rcri_pkg::IDX_PERIPH_FLAG_A))
      begin : g_flag_a
         assign reg_file[i] = periph_flag_reg_a;
      end
      else if (i == int'(rcri_pkg::IDX_PERIPH_FLAG_B))
      begin : g_flag_b
         assign reg_file[i] = periph_flag_reg_b;
      end
      else if (i == int'(rcri_pkg::IDX_POWER_CONTROL))
      begin : g_power_control_reg
         assign reg_file[i] = power_control_reg;
      end
      else
      begin : g_cell
         rcri_init_cell #(
            .CFG(rcri_pkg::CELL_CFG[i])
         ) u_cell (
            .ref_clk(ref_clk),
            .rstn(rstn),
            .cls(cls),
            .wr_hit(wr.en && wr.idx == rcri_pkg::rcri_idx_t'(i)),
            .wr_data(wr.data),
            .q(reg_file[i])
         );
      end
   end

   // ----------------------------------------------------------------
   // Read port
   // ----------------------------------------------------------------
   // Registered read; indices past the file read as zero
   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
         rd_data <= rcri_pkg::BYTE_ZERO;
      else if (int'(rd_idx) < rcri_pkg::REG_COUNT)
         rd_data <= reg_file[rd_idx];
      else
         rd_data <= rcri_pkg::BYTE_ZERO;
   end

endmodule

// ---- hw/rcri_pkg.sv ----
package rcri_pkg;

   // ----------------------------------------------------------------
   // Register file geometry
   // ----------------------------------------------------------------
   localparam int REG_COUNT = 52;
   localparam int IDX_W = 6;
   typedef logic [IDX_W-1:0] rcri_idx_t;

   // Registers with hand-written initialisation logic
   localparam rcri_idx_t IDX_PC_LOW_BYTE = 6'h03;
   localparam rcri_idx_t IDX_STATUS = 6'h04;
   localparam rcri_idx_t IDX_IRQ_CONTROL = 6'h0b;
   localparam rcri_idx_t IDX_PERIPH_FLAG_A = 6'h0c;
   localparam rcri_idx_t IDX_PERIPH_FLAG_B = 6'h0d;
   localparam rcri_idx_t IDX_POWER_CONTROL = 6'h28;

   // ----------------------------------------------------------------
   // Field positions and values
   // ----------------------------------------------------------------
   localparam logic [7:0] STATUS_POWER_VAL = 8'h18;
   localparam logic [7:0] STATUS_BANK_MASK = 8'he0;
   localparam logic [7:0] STATUS_LOW_MASK = 8'h07;
   localparam int STATUS_TO_BIT = 4;
   localparam int STATUS_PD_BIT = 3;
   localparam int POWER_CONTROL_REG_POR_BIT = 1;
   localparam int POWER_CONTROL_REG_BOR_BIT = 0;
   localparam logic [7:0] POWER_CONTROL_REG_IMPL = 8'h03;
   localparam int IRQ_GIE_BIT = 7;
   localparam logic [7:0] IRQ_RESET_KEEP = 8'h01;
   localparam logic [7:0] FLAG_A_IMPL = 8'h7f;
   localparam logic [7:0] FLAG_B_IMPL = 8'h01;
   localparam logic [7:0] PC_RESET_VAL = 8'h00;
   localparam logic [7:0] PC_VECTOR = 8'h04;
   localparam logic [7:0] PC_STEP = 8'h01;
   localparam logic [7:0] BYTE_ZERO = 8'h00;

   // ----------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------
   // Per-register initial behaviour: a set bit in a keep mask holds
   // the prior value, otherwise the bit loads the matching value bit
   typedef struct packed {
      logic [7:0] impl;
      logic [7:0] por_keep;
      logic [7:0] por_val;
      logic [7:0] pin_keep;
      logic [7:0] pin_val;
      logic [7:0] wake_keep;
      logic [7:0] wake_val;
   } rcri_cfg_t;

   typedef struct packed {
      logic power;
      logic pin_wdt;
      logic wake;
   } rcri_class_t;

   typedef struct packed {
      logic por;
      logic bor;
      logic pin;
      logic wdt;
   } rcri_cause_t;

   typedef struct packed {
      logic en;
      rcri_idx_t idx;
      logic [7:0] data;
   } rcri_wr_t;

   typedef struct packed {
      logic [7:0] irq_ctl;
      logic [7:0] flag_a;
      logic [7:0] flag_b;
   } rcri_wake_set_t;

   // ----------------------------------------------------------------
   // Initial behaviour patterns
   // ----------------------------------------------------------------
   localparam rcri_cfg_t CFG_NONE =
      '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
   localparam rcri_cfg_t CFG_UNK =
      '{8'hff, 8'hff, 8'h00, 8'hff, 8'h00, 8'hff, 8'h00};
   localparam rcri_cfg_t CFG_CLR =
      '{8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00};
   localparam rcri_cfg_t CFG_ONES =
      '{8'hff, 8'h00, 8'hff, 8'h00, 8'hff, 8'hff, 8'h00};
   localparam rcri_cfg_t CFG_PORT_A_DATA =
      '{8'h3f, 8'h10, 8'h00, 8'h10, 8'h00, 8'h3f, 8'h00};
   localparam rcri_cfg_t CFG_PORT_E_DATA =
      '{8'h07, 8'h07, 8'h00, 8'h07, 8'h00, 8'h07, 8'h00};
   localparam rcri_cfg_t CFG_HIGH_LATCH =
      '{8'h1f, 8'h00, 8'h00, 8'h00, 8'h00, 8'h1f, 8'h00};
   localparam rcri_cfg_t CFG_TIMER1_CTL =
      '{8'h3f, 8'h00, 8'h00, 8'h3f, 8'h00, 8'h3f, 8'h00};
   localparam rcri_cfg_t CFG_CLR_7F =
      '{8'h7f, 8'h00, 8'h00, 8'h00, 8'h00, 8'h7f, 8'h00};
   localparam rcri_cfg_t CFG_CLR_3F =
      '{8'h3f, 8'h00, 8'h00, 8'h00, 8'h00, 8'h3f, 8'h00};
   localparam rcri_cfg_t CFG_CLR_01 =
      '{8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00};
   localparam rcri_cfg_t CFG_CLR_07 =
      '{8'h07, 8'h00, 8'h00, 8'h00, 8'h00, 8'h07, 8'h00};
   localparam rcri_cfg_t CFG_RX_STATUS =
      '{8'hf7, 8'h01, 8'h00, 8'h01, 8'h00, 8'hf7, 8'h00};
   localparam rcri_cfg_t CFG_TX_STATUS =
      '{8'hf7, 8'h00, 8'h02, 8'h00, 8'h02, 8'hf7, 8'h00};
   localparam rcri_cfg_t CFG_CONV_CTL_A =
      '{8'hfd, 8'h00, 8'h00, 8'h00, 8'h00, 8'hfd, 8'h00};
   localparam rcri_cfg_t CFG_DIR_A =
      '{8'h3f, 8'h00, 8'h3f, 8'h00, 8'h3f, 8'h3f, 8'h00};
   localparam rcri_cfg_t CFG_DIR_E =
      '{8'hf7, 8'h00, 8'h07, 8'h00, 8'h07, 8'hf7, 8'h00};
   localparam rcri_cfg_t CFG_PERIOD =
      '{8'hff, 8'h00, 8'hff, 8'h00, 8'hff, 8'h00, 8'hff};
   localparam rcri_cfg_t CFG_PM_CTL =
      '{8'h03, 8'h00, 8'h02, 8'h00, 8'h02, 8'h01, 8'h02};

   // Index order: work, pointer, timer0, pc, status, port a..e data,
   // high latch, irq ctl, flags a/b, timer1 l/h/ctl, timer2 cnt/ctl,
   // sync buf/ctl, cap1 l/h/ctl, rx stat, tx/rx data, cap2 l/h/ctl,
   // conv result/ctl a, option, dir a..e, enables a/b, power ctl,
   // period, sync stat/addr, tx stat, baud, conv ctl b, pm latch,
   // pm addr, pm data high, pm addr high, pm ctl
   localparam rcri_cfg_t CELL_CFG [REG_COUNT] = '{
      CFG_UNK, CFG_UNK, CFG_UNK, CFG_NONE, CFG_NONE,
      CFG_PORT_A_DATA, CFG_UNK, CFG_UNK, CFG_UNK, CFG_PORT_E_DATA,
      CFG_HIGH_LATCH, CFG_NONE, CFG_NONE, CFG_NONE,
      CFG_UNK, CFG_UNK, CFG_TIMER1_CTL, CFG_CLR, CFG_CLR_7F,
      CFG_UNK, CFG_CLR, CFG_UNK, CFG_UNK, CFG_CLR_3F,
      CFG_RX_STATUS, CFG_CLR, CFG_CLR, CFG_UNK, CFG_UNK, CFG_CLR,
      CFG_UNK, CFG_CONV_CTL_A, CFG_ONES,
      CFG_DIR_A, CFG_ONES, CFG_ONES, CFG_ONES, CFG_DIR_E,
      CFG_CLR_7F, CFG_CLR_01, CFG_NONE,
      CFG_PERIOD, CFG_CLR_3F, CFG_CLR, CFG_TX_STATUS, CFG_CLR,
      CFG_CLR_07, CFG_HIGH_LATCH, CFG_UNK, CFG_UNK, CFG_UNK,
      CFG_PM_CTL
   };

endpackage

// ---- hw/rcri_sync2.sv ----
`timescale 1ns/1ns

module rcri_sync2 #(
   parameter int W = 4
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rstn,
   // Asynchronous levels in, synchronised levels out
   input wire logic [W-1:0] d_async,
   output logic [W-1:0] q_sync
);

   logic [W-1:0] meta;

   // First stage, read only by the second stage
   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
         meta <= '0;
      else
         meta <= d_async;
   end

   // Second stage
   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
         q_sync <= '0;
      else
         q_sync <= meta;
   end

endmodule

// ---- hw/rcri_init_cell.sv ----
`timescale 1ns/1ns

module rcri_init_cell #(
   parameter rcri_pkg::rcri_cfg_t CFG = rcri_pkg::CFG_NONE
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rstn,
   // Reset or wake-up class being applied
   input wire rcri_pkg::rcri_class_t cls,
   // Core write
   input wire logic wr_hit,
   input wire logic [7:0] wr_data,
   // Register value
   output logic [7:0] q
);

   // Class loads win over core writes; unimplemented bits stay zero
   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
         q <= CFG.por_val & CFG.impl;
      else if (cls.power)
         q <= ((q & CFG.por_keep) | CFG.por_val) & CFG.impl;
      else if (cls.pin_wdt)
         q <= ((q & CFG.pin_keep) | CFG.pin_val) & CFG.impl;
      else if (cls.wake)
         q <= ((q & CFG.wake_keep) | CFG.wake_val) & CFG.impl;
      else if (wr_hit)
         q <= wr_data & CFG.impl;
   end

endmodule

// ---- testbench/rcri_reset_init_asserts.sv ----
`timescale 1ns/1ns

module rcri_reset_init_asserts (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rstn,
   // Inputs of the block
   input wire rcri_pkg::rcri_cause_t cause_async,
   input wire logic sleep_enter,
   input wire logic irq_wake,
   input wire rcri_pkg::rcri_wake_set_t wake_set,
   input wire rcri_pkg::rcri_wr_t wr,
   input wire rcri_pkg::rcri_idx_t rd_idx,
   // Outputs of the block
   input wire logic [7:0] rd_data,
   input wire logic [rcri_pkg::REG_COUNT-1:0][7:0] reg_file,
   input wire logic asleep,
   input wire rcri_pkg::rcri_class_t last_class,
   input wire logic vector_taken
);

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rstn);

   // --------------------
   // Sequences
   // --------------------
   // No cause and no write long enough to flush the synchroniser
   sequence quiet_s;
      (cause_async == 4'h0 && !wr.en)[*4];
   endsequence
   sequence power_held_s;
      cause_async.por[*6];
   endsequence
   sequence pin_held_s;
      (cause_async.pin && !cause_async.por && !cause_async.bor)[*6];
   endsequence
   sequence irq_wake_s;
      quiet_s ##0 (asleep && irq_wake);
   endsequence

   // --------------------
   // Assertions
   // --------------------
   AST_VEC_PULSE: assert property (
      vector_taken |=> !vector_taken)
      else $error("vector flag held too long");
   AST_VEC_PC: assert property (
      vector_taken |-> reg_file[3] == 8'h04 && reg_file[4][4:3] == 2'h2)
      else $error("vector taken without vector state");
   AST_WAKE_VEC: assert property (
      irq_wake_s ##0 reg_file[11][7] |=> vector_taken)
      else $error("enabled wake did not vector");
   AST_WAKE_NEXT: assert property (
      irq_wake_s ##0 !reg_file[11][7] |=>
      !vector_taken && reg_file[3] == $past(reg_file[3]) + 8'h01)
      else $error("wake did not advance program counter");
   AST_WAKE_FLAGS: assert property (
      irq_wake_s |=> (reg_file[12] & $past(wake_set.flag_a)) ==
      $past(wake_set.flag_a) && reg_file[41] == 8'hff)
      else $error("wake flags or period wrong");
   AST_WAKE_KEEP: assert property (
      irq_wake_s |=> $stable(reg_file[32]) && $stable(reg_file[16]))
      else $error("wake changed a kept register");
   AST_AWAKE_IGNORE: assert property (
      quiet_s ##0 (!asleep && irq_wake) |=>
      $stable(reg_file[3]) && !vector_taken)
      else $error("interrupt while awake acted");
   AST_UNIMPL: assert property (
      reg_file[18][7] == 1'b0 && reg_file[24][3] == 1'b0 &&
      reg_file[31][1] == 1'b0 && reg_file[37][3] == 1'b0 &&
      reg_file[12][7] == 1'b0)
      else $error("unimplemented bit reads one");
   AST_POWER: assert property (
      power_held_s |-> reg_file[40][1] == 1'b0 && reg_file[16] == 8'h00 &&
      reg_file[4][7:3] == 5'h03)
      else $error("power class values wrong");
   AST_PIN: assert property (
      pin_held_s |-> reg_file[3] == 8'h00 && reg_file[17] == 8'h00 &&
      reg_file[11][7:1] == 7'h00)
      else $error("pin class values wrong");
   AST_DIRS: assert property (
      cause_async.pin[*6] |-> reg_file[32] == 8'hff &&
      reg_file[33] == 8'h3f && reg_file[37] == 8'h07 && reg_file[41] == 8'hff)
      else $error("direction or period not set");

endmodule

bind rcri_reset_init rcri_reset_init_asserts rcri_reset_init_asserts_inst (
   .ref_clk(ref_clk), .rstn(rstn), .cause_async(cause_async),
   .sleep_enter(sleep_enter), .irq_wake(irq_wake), .wake_set(wake_set),
   .wr(wr), .rd_idx(rd_idx), .rd_data(rd_data), .reg_file(reg_file),
   .asleep(asleep), .last_class(last_class), .vector_taken(vector_taken)
);

// ---- testbench/testbench.sv ----
`timescale 1ns/1ns

module testbench;

   // --------------------
   // Signals and block
   // --------------------
   logic ref_clk = 1'b0;
   logic rstn = 1'b0;
   rcri_pkg::rcri_cause_t cause_async = '0;
   logic sleep_enter = 1'b0;
   logic irq_wake = 1'b0;
   rcri_pkg::rcri_wake_set_t wake_set = '0;
   rcri_pkg::rcri_wr_t wr = '0;
   rcri_pkg::rcri_idx_t rd_idx = '0;
   logic [7:0] rd_data;
   logic [rcri_pkg::REG_COUNT-1:0][7:0] reg_file;
   logic asleep;
   rcri_pkg::rcri_class_t last_class;
   logic vector_taken;
   int mismatches = 0;
   int checks = 0;
   int cycles = 0;
   int vec_count = 0;
   int ff_idx [7] = '{18, 31, 44, 5, 12, 38, 37};
   logic [7:0] ff_exp [7] = '{8'h7f, 8'hfd, 8'hf7, 8'h3f, 8'h7f, 8'h7f, 8'hf7};
   int w_idx [6] = '{11, 3, 41, 34, 17, 12};
   logic [7:0] w_dat [6] = '{8'h80, 8'h10, 8'h00, 8'h12, 8'h5c, 8'h00};

   rcri_reset_init rcri_reset_init_inst (
      .ref_clk(ref_clk), .rstn(rstn), .cause_async(cause_async),
      .sleep_enter(sleep_enter), .irq_wake(irq_wake), .wake_set(wake_set),
      .wr(wr), .rd_idx(rd_idx), .rd_data(rd_data), .reg_file(reg_file),
      .asleep(asleep), .last_class(last_class), .vector_taken(vector_taken)
   );

   // Clock
   always #2 ref_clk = ~ref_clk;

   // Cycle ceiling and vector pulse count
   always @(posedge ref_clk)
   begin
      cycles <= cycles + 1;
      if (vector_taken === 1'b1)
         vec_count <= vec_count + 1;
      if (cycles == 8000)
      begin
         mismatches = mismatches + 1;
         print_verdict();
      end
   end

   // --------------------
   // Tasks
   // --------------------
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic check(input string name, input logic [7:0] seen,
                        input logic [7:0] exp);
      checks = checks + 1;
      if (seen !== exp)
      begin
         mismatches = mismatches + 1;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
   endtask

   // One-cycle core write
   task automatic write_reg(input int i, input logic [7:0] d);
      @(posedge ref_clk);
      wr <= '{1'b1, 6'(i), d};
      @(posedge ref_clk);
      wr <= '0;
   endtask

   // Read through the registered port, compare the cared bits
   task automatic read_chk(input int i, input logic [7:0] care,
                           input logic [7:0] exp);
      @(posedge ref_clk);
      rd_idx <= 6'(i);
      tick(2);
      #1;
      check($sformatf("reg %0d", i), rd_data & care, exp);
   endtask

   // Value after a class applied over a prior of b7 everywhere
   function automatic logic [15:0] expect_after(input int i, input bit pwr);
      case (i)
         0, 1, 2, 6, 7, 8, 14, 15, 19, 21, 22, 27, 28, 30, 48, 49, 50:
            return 16'hffb7;
         4: return pwr ? 16'hf818 : 16'hff17;
         5: return 16'hff10;
         9, 37: return 16'hff07;
         11, 24: return 16'hff01;
         16: return pwr ? 16'hff00 : 16'hff37;
         32, 34, 35, 36, 41: return 16'hffff;
         33: return 16'hff3f;
         40: return pwr ? 16'hff01 : 16'hff03;
         44, 51: return 16'hff02;
         default: return 16'hff00;
      endcase
   endfunction

   task automatic read_exp(input int i, input bit pwr);
      logic [15:0] ce;
      ce = expect_after(i, pwr);
      read_chk(i, ce[15:8], ce[7:0]);
   endtask

   // Hold a cause, try a write meanwhile, then release and settle
   task automatic pulse_cause(input rcri_pkg::rcri_cause_t c, input int n);
      @(posedge ref_clk);
      cause_async <= c;
      tick(3);
      write_reg(17, 8'h33);
      tick(n);
      cause_async <= '0;
      tick(6);
   endtask

   task automatic go_sleep;
      @(posedge ref_clk);
      sleep_enter <= 1'b1;
      @(posedge ref_clk);
      sleep_enter <= 1'b0;
      tick(2);
      check("asleep", {7'h00, asleep}, 8'h01);
   endtask

   task automatic irq_pulse;
      @(posedge ref_clk);
      irq_wake <= 1'b1;
      @(posedge ref_clk);
      irq_wake <= 1'b0;
      tick(3);
   endtask

   // --------------------
   // Sequence of tests
   // --------------------
   initial
   begin
      tick(6);
      rstn <= 1'b1;
      tick(3);
      read_chk(4, 8'hff, 8'h18);
      read_chk(41, 8'hff, 8'hff);
      read_chk(44, 8'hff, 8'h02);
      // Unimplemented and reserved bits
      foreach (ff_idx[k])
      begin
         write_reg(ff_idx[k], 8'hff);
         read_chk(ff_idx[k], 8'hff, ff_exp[k]);
      end
      // Pin class, then power class together with pin
      for (int p = 0; p < 2; p++)
      begin
         for (int i = 0; i < 52; i++)
            write_reg(i, 8'hb7);
         pulse_cause(p ? 4'ha : 4'h2, 8);
         check("last_class", {5'h00, last_class}, p ? 8'h04 : 8'h02);
         for (int i = 0; i < 52; i++)
            read_exp(i, p[0]);
      end
      // Brown-out
      write_reg(40, 8'h03);
      write_reg(16, 8'h15);
      pulse_cause(4'h4, 8);
      read_chk(40, 8'hff, 8'h02);
      read_chk(16, 8'hff, 8'h00);
      read_chk(4, 8'hf8, 8'h18);
      // Interrupt wake with the global enable set
      foreach (w_idx[k])
         write_reg(w_idx[k], w_dat[k]);
      wake_set <= '{8'h02, 8'h01, 8'h01};
      go_sleep();
      irq_pulse();
      read_chk(3, 8'hff, 8'h04);
      read_chk(4, 8'h18, 8'h10);
      read_chk(12, 8'hff, 8'h01);
      read_chk(11, 8'h02, 8'h02);
      read_chk(13, 8'hff, 8'h01);
      read_chk(41, 8'hff, 8'hff);
      read_chk(34, 8'hff, 8'h12);
      read_chk(17, 8'hff, 8'h5c);
      check("vec_count", 8'(vec_count), 8'h01);
      check("awake", {7'h00, asleep}, 8'h00);
      check("last_class", {5'h00, last_class}, 8'h01);
      // Wake without the enable, then interrupt while awake
      write_reg(11, 8'h00);
      write_reg(3, 8'h2f);
      go_sleep();
      irq_pulse();
      read_chk(3, 8'hff, 8'h30);
      irq_pulse();
      read_chk(3, 8'hff, 8'h30);
      check("vec_count", 8'(vec_count), 8'h01);
      // Watchdog wake, then watchdog reset
      go_sleep();
      pulse_cause(4'h1, 3);
      read_chk(3, 8'hff, 8'h31);
      read_chk(4, 8'h18, 8'h00);
      pulse_cause(4'h1, 3);
      read_chk(3, 8'hff, 8'h00);
      read_chk(4, 8'hf8, 8'h08);
      check("last_class", {5'h00, last_class}, 8'h02);
      // Pin reset during sleep
      go_sleep();
      pulse_cause(4'h2, 8);
      read_chk(4, 8'hf8, 8'h10);
      check("asleep", {7'h00, asleep}, 8'h00);
      // Unmapped index
      read_chk(60, 8'hff, 8'h00);
      print_verdict();
   end

endmodule
